// [hdl/regulator_event_pkg.sv]
// Package with offsets, field positions, reset values and timing counts of the event and status registers.
package regulator_event_pkg;

	localparam logic [7:0] LINEAR_EVENT_FLAGS_OFFSET = 8'h1c;
	localparam logic [7:0] TOP_CONDITION_STATUS_OFFSET = 8'h1d;
	localparam logic [7:0] BUCK_CONDITION_STATUS_OFFSET = 8'h1e;

	localparam int LINEAR0_LIMIT_BIT = 0;
	localparam int LINEAR0_SHORT_BIT = 1;
	localparam int LINEAR0_GOOD_BIT = 2;
	localparam int LINEAR1_LIMIT_BIT = 4;
	localparam int LINEAR1_SHORT_BIT = 5;
	localparam int LINEAR1_GOOD_BIT = 6;

	localparam int POWER_GOOD_PIN_BIT = 7;
	localparam int SYNC_CLOCK_INVALID_BIT = 4;
	localparam int THERMAL_SHUTDOWN_BIT = 3;
	localparam int THERMAL_WARNING_BIT = 2;
	localparam int INPUT_OVERVOLTAGE_BIT = 1;

	localparam int BUCK_B_ENABLED_BIT = 7;
	localparam int BUCK_B_INVALID_BIT = 6;
	localparam int BUCK_B_LIMIT_BIT = 4;
	localparam int BUCK_A_ENABLED_BIT = 3;
	localparam int BUCK_A_INVALID_BIT = 2;
	localparam int BUCK_A_LIMIT_BIT = 0;

	localparam logic [7:0] LINEAR_EVENT_FLAGS_RESET = 8'h00;
	localparam logic [7:0] LINEAR_EVENT_MASK = 8'h77;

	localparam int CLOCK_HZ = 40000000;
	localparam int SHORT_TIME_US = 1000;
	// More than 1 ms: the level must last longer than this many cycles.
	localparam int SHORT_CYCLES = (SHORT_TIME_US * (CLOCK_HZ / 1000000));
	localparam int SHORT_COUNT_W = 16;

	typedef struct packed {
		logic power_good_output;
		logic sync_clock_invalid;
		logic thermal_shutdown;
		logic thermal_warning;
		logic input_overvoltage;
	} top_conditions_t;

	typedef struct packed {
		logic buck_b_enabled;
		logic buck_b_invalid;
		logic buck_b_limit;
		logic buck_a_enabled;
		logic buck_a_invalid;
		logic buck_a_limit;
	} buck_conditions_t;

	typedef struct packed {
		logic good_event;
		logic below_short;
		logic limit_active;
	} linear_detect_t;

	typedef struct packed {
		logic write_strobe;
		logic [7:0] address;
		logic [7:0] write_data;
	} register_request_t;

endpackage

// [hdl/level_synchronizer.sv]
// Two-flop synchroniser for a vector of asynchronous condition levels.
`timescale 1ns/100ps
module level_synchronizer
	import regulator_event_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_t;

	sync_state_t state_q;
	sync_state_t state_d;

	always_comb
	begin
		state_d.first = async_i;
		state_d.second = state_q.first;
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q <= '0;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	assign sync_o = state_q.second;

endmodule // level_synchronizer

// [hdl/short_timer.sv]
// Qualifies a below-threshold level and pulses once it has lasted more than 1 ms.
`timescale 1ns/100ps
module short_timer
	import regulator_event_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic below_i,
	output logic expired_o
);

	typedef struct packed {
		logic [SHORT_COUNT_W-1:0] count;
		logic fired;
	} timer_state_t;

	localparam logic [SHORT_COUNT_W-1:0] LIMIT = SHORT_COUNT_W'(SHORT_CYCLES);

	timer_state_t state_q;
	timer_state_t state_d;
	logic expire;

	always_comb
	begin
		state_d = state_q;
		expire = 1'b0;
		if (!below_i)
		begin
			state_d.count = '0;
			state_d.fired = 1'b0;
		end
		else if (state_q.count < LIMIT)
		begin
			state_d.count = state_q.count + 1'b1;
		end
		else if (!state_q.fired)
		begin
			// Count has reached the limit while still below: the level lasted more than 1 ms.
			expire = 1'b1;
			state_d.fired = 1'b1;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q <= '0;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	assign expired_o = expire;

endmodule // short_timer

// [hdl/regulator_event_status_regs.sv]
// Event and condition status registers of the dual buck, dual linear regulator manager.
//
// What this block does
// (R1) Latch bit 6 on linear1 good event.
// (R2) Latch bit 5 after linear1 short over 1 ms.
// (R3) Latch bit 4 on linear1 current limit.
// (R4) Latch bit 2 on linear0 good event.
// (R5) Latch bit 1 after linear0 short over 1 ms.
// (R6) Latch bit 0 on linear0 current limit.
// (R7) Flags clear only by writing one.
// (R8) Top bit 7 follows power good pin.
// (R9) Top bit 4 high when sync clock invalid.
// (R10) Top bit 3 high above thermal shutdown.
// (R11) Top bit 2 high above thermal warning.
// (R12) Top bit 1 high during input overvoltage.
// (R13) Buck bit 7 shows buck b enabled.
// (R14) Buck bit 6 high when buck b invalid.
// (R15) Buck bit 4 shows buck b limit.
// (R16) Buck bit 3 shows buck a enabled.
// (R17) Buck bit 2 high when buck a invalid.
// (R18) Buck bit 0 shows buck a limit.
// (R19) Summary flag clears when all flags zero.
// (R20) Event wins over simultaneous clear.
`timescale 1ns/100ps
module regulator_event_status_regs
	import regulator_event_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire register_request_t request_i,
	input wire linear_detect_t linear0_i,
	input wire linear_detect_t linear1_i,
	input wire top_conditions_t top_i,
	input wire buck_conditions_t buck_i,
	output logic [7:0] read_data_o,
	output logic linear_summary_flag_o
);

	typedef struct packed {
		logic [7:0] linear_event_flags;
		logic [7:0] read_data;
		logic [1:0] good_prev;
		logic [1:0] limit_prev;
		// Watch-only run length of each below-threshold level, saturating, read by assertions.
		logic [1:0][SHORT_COUNT_W-1:0] below_run;
	} regs_state_t;

	localparam int DET_W = 6;
	localparam int TOP_W = 5;
	localparam int BUCK_W = 6;
	localparam logic [SHORT_COUNT_W-1:0] SHORT_RUN = SHORT_COUNT_W'(SHORT_CYCLES);

	regs_state_t state_q;
	regs_state_t state_d;
	logic [DET_W-1:0] det_sync;
	logic [TOP_W-1:0] top_sync;
	logic [BUCK_W-1:0] buck_sync;
	logic [1:0] short_expired;
	logic [1:0] good_level;
	logic [1:0] below_level;
	logic [1:0] limit_level;
	logic [7:0] event_set;
	logic [7:0] clear_mask;
	logic [7:0] top_word;
	logic [7:0] buck_word;

	// Analog detector outputs are asynchronous to mclk_i and are synchronised first.
	level_synchronizer #(
		.WIDTH(DET_W)
	) det_sync_inst (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.async_i({linear1_i, linear0_i}),
		.sync_o(det_sync)
	);

	level_synchronizer #(
		.WIDTH(TOP_W)
	) top_sync_inst (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.async_i(top_i),
		.sync_o(top_sync)
	);

	level_synchronizer #(
		.WIDTH(BUCK_W)
	) buck_sync_inst (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.async_i(buck_i),
		.sync_o(buck_sync)
	);

	assign good_level = {det_sync[5], det_sync[2]};
	assign below_level = {det_sync[4], det_sync[1]};
	assign limit_level = {det_sync[3], det_sync[0]};

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_short
			short_timer short_inst (
				.mclk_i(mclk_i),
				.rst_i(rst_i),
				.below_i(below_level[ch]),
				.expired_o(short_expired[ch])
			);
		end
	endgenerate

	always_comb
	begin
		event_set = 8'h00;
		// Good and limit detectors are levels; a rising edge latches the flag so a cleared
		// flag is not set again by a condition that simply persists.
		event_set[LINEAR0_GOOD_BIT] = good_level[0] & ~state_q.good_prev[0]; // R4
		event_set[LINEAR1_GOOD_BIT] = good_level[1] & ~state_q.good_prev[1]; // R1
		event_set[LINEAR0_SHORT_BIT] = short_expired[0]; // R5
		event_set[LINEAR1_SHORT_BIT] = short_expired[1]; // R2
		event_set[LINEAR0_LIMIT_BIT] = limit_level[0] & ~state_q.limit_prev[0]; // R6
		event_set[LINEAR1_LIMIT_BIT] = limit_level[1] & ~state_q.limit_prev[1]; // R3
	end

	assign clear_mask = (request_i.write_strobe
		&& request_i.address == LINEAR_EVENT_FLAGS_OFFSET) ? request_i.write_data : 8'h00; // R7

	always_comb
	begin
		top_word = 8'h00;
		top_word[POWER_GOOD_PIN_BIT] = top_sync[4]; // R8
		top_word[SYNC_CLOCK_INVALID_BIT] = top_sync[3]; // R9
		top_word[THERMAL_SHUTDOWN_BIT] = top_sync[2]; // R10
		top_word[THERMAL_WARNING_BIT] = top_sync[1]; // R11
		top_word[INPUT_OVERVOLTAGE_BIT] = top_sync[0]; // R12
		buck_word = 8'h00;
		buck_word[BUCK_B_ENABLED_BIT] = buck_sync[5]; // R13
		buck_word[BUCK_B_INVALID_BIT] = buck_sync[4]; // R14
		buck_word[BUCK_B_LIMIT_BIT] = buck_sync[3]; // R15
		buck_word[BUCK_A_ENABLED_BIT] = buck_sync[2]; // R16
		buck_word[BUCK_A_INVALID_BIT] = buck_sync[1]; // R17
		buck_word[BUCK_A_LIMIT_BIT] = buck_sync[0]; // R18
	end

	always_comb
	begin
		state_d = state_q;
		state_d.good_prev = good_level;
		state_d.limit_prev = limit_level;
		for (int i = 0; i < 2; i++)
		begin
			if (!below_level[i])
			begin
				state_d.below_run[i] = '0;
			end
			else if (state_q.below_run[i] != '1)
			begin
				state_d.below_run[i] = state_q.below_run[i] + 1'b1;
			end
		end
		// Set is applied after the clear so a same-cycle event survives.
		state_d.linear_event_flags = ((state_q.linear_event_flags & ~clear_mask)
			| event_set) & LINEAR_EVENT_MASK; // R7 R20
		unique case (request_i.address)
			LINEAR_EVENT_FLAGS_OFFSET: state_d.read_data = state_q.linear_event_flags;
			TOP_CONDITION_STATUS_OFFSET: state_d.read_data = top_word;
			BUCK_CONDITION_STATUS_OFFSET: state_d.read_data = buck_word;
			default: state_d.read_data = 8'h00;
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q.linear_event_flags <= LINEAR_EVENT_FLAGS_RESET;
			state_q.read_data <= 8'h00;
			state_q.good_prev <= 2'b00;
			state_q.limit_prev <= 2'b00;
			state_q.below_run <= '0;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	assign read_data_o = state_q.read_data;
	assign linear_summary_flag_o = |state_q.linear_event_flags; // R19

	AST_FLAG_CLEARS: assert property (@(posedge mclk_i) disable iff (rst_i) // R7
		(clear_mask[LINEAR0_LIMIT_BIT] && !event_set[LINEAR0_LIMIT_BIT])
		|=> !state_q.linear_event_flags[LINEAR0_LIMIT_BIT])
		else $error("Flag not cleared by write one.");

	AST_ZERO_KEEPS: assert property (@(posedge mclk_i) disable iff (rst_i) // R7
		(!clear_mask[LINEAR1_GOOD_BIT] && state_q.linear_event_flags[LINEAR1_GOOD_BIT])
		|=> state_q.linear_event_flags[LINEAR1_GOOD_BIT])
		else $error("Flag lost without write one.");

	AST_SET_WINS: assert property (@(posedge mclk_i) disable iff (rst_i) // R20
		(event_set[LINEAR0_LIMIT_BIT] && clear_mask[LINEAR0_LIMIT_BIT])
		|=> state_q.linear_event_flags[LINEAR0_LIMIT_BIT])
		else $error("Event lost during clear.");

	AST_LIMIT1_LATCH: assert property (@(posedge mclk_i) disable iff (rst_i) // R3
		$rose(limit_level[1]) |=> state_q.linear_event_flags[LINEAR1_LIMIT_BIT])
		else $error("Linear1 limit not latched.");

	AST_GOOD1_LATCH: assert property (@(posedge mclk_i) disable iff (rst_i) // R1
		$rose(good_level[1]) |=> state_q.linear_event_flags[LINEAR1_GOOD_BIT])
		else $error("Linear1 good event not latched.");

	AST_SHORT0_TIME: assert property (@(posedge mclk_i) disable iff (rst_i) // R5
		$rose(below_level[0]) |-> !short_expired[0] [*8])
		else $error("Short flagged too early.");

	AST_SHORT1_LATCH: assert property (@(posedge mclk_i) disable iff (rst_i) // R2
		short_expired[1] |=> state_q.linear_event_flags[LINEAR1_SHORT_BIT])
		else $error("Linear1 short not latched.");

	AST_SUMMARY: assert property (@(posedge mclk_i) disable iff (rst_i) // R19
		(state_q.linear_event_flags == 8'h00) |-> !linear_summary_flag_o)
		else $error("Summary flag set with no events.");

	AST_TOP_READ: assert property (@(posedge mclk_i) disable iff (rst_i) // R10
		(request_i.address == TOP_CONDITION_STATUS_OFFSET)
		|=> read_data_o[THERMAL_SHUTDOWN_BIT] == $past(top_sync[2]))
		else $error("Thermal shutdown readback wrong.");

	AST_BUCK_READ: assert property (@(posedge mclk_i) disable iff (rst_i) // R14
		(request_i.address == BUCK_CONDITION_STATUS_OFFSET)
		|=> read_data_o[BUCK_B_INVALID_BIT] == $past(buck_sync[4]))
		else $error("Buck b validity readback wrong.");

	AST_GOOD0_LATCH: assert property (@(posedge mclk_i) disable iff (rst_i) // R4
		$rose(good_level[0]) |=> state_q.linear_event_flags[LINEAR0_GOOD_BIT])
		else $error("Linear0 good event not latched.");

	AST_LIMIT0_LATCH: assert property (@(posedge mclk_i) disable iff (rst_i) // R6
		$rose(limit_level[0]) |=> state_q.linear_event_flags[LINEAR0_LIMIT_BIT])
		else $error("Linear0 limit not latched.");

	AST_LIMIT0_QUIET: assert property (@(posedge mclk_i) disable iff (rst_i) // R6
		(!event_set[LINEAR0_LIMIT_BIT] && !state_q.linear_event_flags[LINEAR0_LIMIT_BIT])
		|=> !state_q.linear_event_flags[LINEAR0_LIMIT_BIT])
		else $error("Linear0 limit set without an event.");

	AST_SHORT0_LATCH: assert property (@(posedge mclk_i) disable iff (rst_i) // R5
		short_expired[0] |=> state_q.linear_event_flags[LINEAR0_SHORT_BIT])
		else $error("Linear0 short not latched.");

	AST_SHORT0_EXACT: assert property (@(posedge mclk_i) disable iff (rst_i) // R5
		short_expired[0] |-> (state_q.below_run[0] == SHORT_RUN))
		else $error("Linear0 short flagged at the wrong time.");

	AST_SHORT0_FIRES: assert property (@(posedge mclk_i) disable iff (rst_i) // R5
		(below_level[0] && state_q.below_run[0] == SHORT_RUN)
		|-> short_expired[0])
		else $error("Linear0 short not flagged after full time.");

	AST_SHORT1_EXACT: assert property (@(posedge mclk_i) disable iff (rst_i) // R2
		short_expired[1] |-> (state_q.below_run[1] == SHORT_RUN))
		else $error("Linear1 short flagged at the wrong time.");

	AST_SHORT1_FIRES: assert property (@(posedge mclk_i) disable iff (rst_i) // R2
		(below_level[1] && state_q.below_run[1] == SHORT_RUN)
		|-> short_expired[1])
		else $error("Linear1 short not flagged after full time.");

	AST_SUMMARY_CLEAR: assert property (@(posedge mclk_i) disable iff (rst_i) // R19
		(clear_mask == 8'hff && event_set == 8'h00)
		|=> !linear_summary_flag_o)
		else $error("Summary flag kept after full clear.");

	AST_POWER_GOOD_READ: assert property (@(posedge mclk_i) disable iff (rst_i) // R8
		(request_i.address == TOP_CONDITION_STATUS_OFFSET)
		|=> read_data_o[POWER_GOOD_PIN_BIT] == $past(top_sync[4]))
		else $error("Power good readback wrong.");

	AST_SYNC_CLOCK_READ: assert property (@(posedge mclk_i) disable iff (rst_i) // R9
		(request_i.address == TOP_CONDITION_STATUS_OFFSET)
		|=> read_data_o[SYNC_CLOCK_INVALID_BIT] == $past(top_sync[3]))
		else $error("Sync clock readback wrong.");

	AST_WARNING_READ: assert property (@(posedge mclk_i) disable iff (rst_i) // R11
		(request_i.address == TOP_CONDITION_STATUS_OFFSET)
		|=> read_data_o[THERMAL_WARNING_BIT] == $past(top_sync[1]))
		else $error("Thermal warning readback wrong.");

	AST_OVERVOLTAGE_READ: assert property (@(posedge mclk_i) disable iff (rst_i) // R12
		(request_i.address == TOP_CONDITION_STATUS_OFFSET)
		|=> read_data_o[INPUT_OVERVOLTAGE_BIT] == $past(top_sync[0]))
		else $error("Overvoltage readback wrong.");

	AST_BUCKB_EN_READ: assert property (@(posedge mclk_i) disable iff (rst_i) // R13
		(request_i.address == BUCK_CONDITION_STATUS_OFFSET)
		|=> read_data_o[BUCK_B_ENABLED_BIT] == $past(buck_sync[5]))
		else $error("Buck b enable readback wrong.");

	AST_BUCKB_LIM_READ: assert property (@(posedge mclk_i) disable iff (rst_i) // R15
		(request_i.address == BUCK_CONDITION_STATUS_OFFSET)
		|=> read_data_o[BUCK_B_LIMIT_BIT] == $past(buck_sync[3]))
		else $error("Buck b limit readback wrong.");

	AST_BUCKA_EN_READ: assert property (@(posedge mclk_i) disable iff (rst_i) // R16
		(request_i.address == BUCK_CONDITION_STATUS_OFFSET)
		|=> read_data_o[BUCK_A_ENABLED_BIT] == $past(buck_sync[2]))
		else $error("Buck a enable readback wrong.");

	AST_BUCKA_INV_READ: assert property (@(posedge mclk_i) disable iff (rst_i) // R17
		(request_i.address == BUCK_CONDITION_STATUS_OFFSET)
		|=> read_data_o[BUCK_A_INVALID_BIT] == $past(buck_sync[1]))
		else $error("Buck a validity readback wrong.");

	AST_BUCKA_LIM_READ: assert property (@(posedge mclk_i) disable iff (rst_i) // R18
		(request_i.address == BUCK_CONDITION_STATUS_OFFSET)
		|=> read_data_o[BUCK_A_LIMIT_BIT] == $past(buck_sync[0]))
		else $error("Buck a limit readback wrong.");

endmodule // regulator_event_status_regs

// [verification/host_register_model.sv]
// Host model that issues single-byte register writes and reads to the event block.
`timescale 1ns/100ps
module host_register_model
	import regulator_event_pkg::*;
(
	input wire logic mclk_i,
	input wire logic [7:0] read_data_i,
	output register_request_t request_o
);
	initial request_o = '0;

	// Callers enter 1 ns after an edge; the request is held across the taking edge.
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		request_o = {1'b1, addr, data};
		@(posedge mclk_i);
		#1;
		// Stale data is inverted so that nothing leans on a held value.
		request_o = {1'b0, addr, ~data};
		// One idle edge keeps the strobe low between back-to-back writes.
		@(posedge mclk_i);
		#1;
	endtask

	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		request_o.address = addr;
		@(posedge mclk_i);
		#1;
		data = read_data_i;
	endtask
endmodule // host_register_model

// [verification/test_regulator_event_status_regs.sv]
// Self-checking testbench for the regulator event and condition status registers.
`timescale 1ns/100ps
module test_regulator_event_status_regs
	import regulator_event_pkg::*;
;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	register_request_t request;
	linear_detect_t linear0 = '0;
	linear_detect_t linear1 = '0;
	top_conditions_t top = '0;
	buck_conditions_t buck = '0;
	logic [7:0] read_data;
	logic summary;
	logic [7:0] got;
	logic [4:0] top_pat [3] = '{5'h1f, 5'h15, 5'h0a};
	logic [5:0] buck_pat [3] = '{6'h3f, 6'h2a, 6'h15};
	logic [7:0] ev_exp [4] = '{8'h01, 8'h05, 8'h15, 8'h55};
	int fail_count = 0;
	int samples_checked = 0;

	always #12.5 mclk_i = ~mclk_i;

	host_register_model host_register_model_inst (
		.mclk_i(mclk_i),
		.read_data_i(read_data),
		.request_o(request)
	);

	regulator_event_status_regs regulator_event_status_regs_inst (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.request_i(request),
		.linear0_i(linear0),
		.linear1_i(linear1),
		.top_i(top),
		.buck_i(buck),
		.read_data_o(read_data),
		.linear_summary_flag_o(summary)
	);

	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge mclk_i);
			#1;
		end
	endtask

	task automatic check(input logic [7:0] exp_v);
		samples_checked++;
		if (got !== exp_v)
		begin
			fail_count++;
			$display("mismatch at %0t: read %h expected %h", $time, got, exp_v);
		end
	endtask

	task automatic rd(input logic [7:0] addr, input logic [7:0] exp_v);
		host_register_model_inst.read_reg(addr, got);
		check(exp_v);
	endtask

	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		host_register_model_inst.write_reg(addr, data);
	endtask

	task automatic sum_check(input logic exp_v);
		got = {7'h00, summary};
		check({7'h00, exp_v});
	endtask

	function automatic logic [7:0] top_exp(input top_conditions_t t);
		logic [7:0] v;
		v = 8'h00;
		v[POWER_GOOD_PIN_BIT] = t.power_good_output;
		v[SYNC_CLOCK_INVALID_BIT] = t.sync_clock_invalid;
		v[THERMAL_SHUTDOWN_BIT] = t.thermal_shutdown;
		v[THERMAL_WARNING_BIT] = t.thermal_warning;
		v[INPUT_OVERVOLTAGE_BIT] = t.input_overvoltage;
		return v;
	endfunction

	function automatic logic [7:0] buck_exp(input buck_conditions_t b);
		logic [7:0] v;
		v = 8'h00;
		v[BUCK_B_ENABLED_BIT] = b.buck_b_enabled;
		v[BUCK_B_INVALID_BIT] = b.buck_b_invalid;
		v[BUCK_B_LIMIT_BIT] = b.buck_b_limit;
		v[BUCK_A_ENABLED_BIT] = b.buck_a_enabled;
		v[BUCK_A_INVALID_BIT] = b.buck_a_invalid;
		v[BUCK_A_LIMIT_BIT] = b.buck_a_limit;
		return v;
	endfunction

	task automatic final_report();
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		repeat (60000) @(posedge mclk_i);
		fail_count++;
		$display("mismatch at %0t: run did not finish", $time);
		final_report();
	end

	initial
	begin
		tick(16);
		rst_i = 1'b0;
		rd(LINEAR_EVENT_FLAGS_OFFSET, 8'h00);
		rd(8'h00, 8'h00);
		rd(8'h1f, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 3; i++)
		begin
			top = top_pat[i];
			buck = buck_pat[i];
			tick(4);
			rd(TOP_CONDITION_STATUS_OFFSET, top_exp(top));
			rd(BUCK_CONDITION_STATUS_OFFSET, buck_exp(buck));
		end
		top = '0;
		buck = '0;
		$display("test status done");
		// Each event is added alone so that a swapped bit shows up.
		for (int i = 0; i < 4; i++)
		begin
			case (i)
				0: linear0.limit_active = 1'b1;
				1: linear0.good_event = 1'b1;
				2: linear1.limit_active = 1'b1;
				default: linear1.good_event = 1'b1;
			endcase
			tick(4);
			rd(LINEAR_EVENT_FLAGS_OFFSET, ev_exp[i]);
		end
		linear0 = '0;
		linear1 = '0;
		tick(4);
		sum_check(1'b1);
		wr(LINEAR_EVENT_FLAGS_OFFSET, 8'h00);
		rd(LINEAR_EVENT_FLAGS_OFFSET, 8'h55);
		wr(TOP_CONDITION_STATUS_OFFSET, 8'hff);
		rd(LINEAR_EVENT_FLAGS_OFFSET, 8'h55);
		rd(TOP_CONDITION_STATUS_OFFSET, 8'h00);
		wr(LINEAR_EVENT_FLAGS_OFFSET, 8'h01);
		rd(LINEAR_EVENT_FLAGS_OFFSET, 8'h54);
		wr(LINEAR_EVENT_FLAGS_OFFSET, 8'haa);
		rd(LINEAR_EVENT_FLAGS_OFFSET, 8'h54);
		sum_check(1'b1);
		wr(LINEAR_EVENT_FLAGS_OFFSET, 8'hff);
		rd(LINEAR_EVENT_FLAGS_OFFSET, 8'h00);
		sum_check(1'b0);
		$display("test events done");
		// The write is taken on the edge where the event latches.
		linear0.limit_active = 1'b1;
		tick(2);
		wr(LINEAR_EVENT_FLAGS_OFFSET, 8'h01);
		tick(3);
		rd(LINEAR_EVENT_FLAGS_OFFSET, 8'h01);
		linear0 = '0;
		wr(LINEAR_EVENT_FLAGS_OFFSET, 8'h01);
		$display("test collision done");
		linear0.below_short = 1'b1;
		linear1.below_short = 1'b1;
		// Two synchroniser stages, then the level must outlast the whole count before it latches.
		tick(SHORT_CYCLES + 2);
		rd(LINEAR_EVENT_FLAGS_OFFSET, 8'h00);
		rd(LINEAR_EVENT_FLAGS_OFFSET, 8'h22);
		$display("test short done");
		rst_i = 1'b1;
		tick(2);
		rst_i = 1'b0;
		rd(LINEAR_EVENT_FLAGS_OFFSET, 8'h00);
		sum_check(1'b0);
		$display("test second reset done");
		final_report();
	end
endmodule // test_regulator_event_status_regs
